// ---- include/swr_params.svh ----
// Offsets, field positions, reset values and timing counts of the supervisor block
`ifndef SWR_PARAMS_SVH
`define SWR_PARAMS_SVH

`define SWR_CLK_HZ 20000000
`define SWR_TICK_US 1000
`define SWR_TICK_CYCLES ((`SWR_CLK_HZ / 1000000) * `SWR_TICK_US)

`define SWR_RST_PULSE_MS 12'h032
`define SWR_RST_PULSE_LONG_MS 12'h0C8
`define SWR_WD_FAST_MS 13'h0064
`define SWR_WD_SLOW_MS 13'h0640
`define SWR_RST_PULSE_CLKS 12'h200
`define SWR_RST_PULSE_LONG_CLKS 12'h800
`define SWR_WD_NORMAL_CLKS 13'h0400
`define SWR_WD_AFTER_RST_CLKS 13'h1000

`define SWR_ADDR_CTRL 5'h00
`define SWR_ADDR_STATUS 5'h04
`define SWR_ADDR_EVENT 5'h08
`define SWR_ADDR_EVENT_CLEAR 5'h0C
`define SWR_ADDR_EVENT_ENABLE 5'h10

`define SWR_CTRL_WD_EN 0
`define SWR_CTRL_RESET 1'h1
`define SWR_EVENT_RESET 4'h0
`define SWR_EVENT_ENABLE_RESET 4'h0

`define SWR_EV_WD_TIMEOUT 0
`define SWR_EV_UNDERVOLT 1
`define SWR_EV_POWER_FAIL 2
`define SWR_EV_BACKUP 3

`define SWR_SYNC_WIDTH 8
`define SWR_SI_WDI 0
`define SWR_SI_WDI_FLOAT 1
`define SWR_SI_TB_LEVEL 2
`define SWR_SI_TB_FLOAT 3
`define SWR_SI_TB_SELECT 4
`define SWR_SI_UNDERVOLT 5
`define SWR_SI_POWER_FAIL 6
`define SWR_SI_BACKUP 7

`endif

// ---- include/swr_pkg.sv ----
// Types shared by the supervisor block
`default_nettype none
package swr_pkg;

	typedef struct packed {
		logic wdi_prev;
		logic wdi_valid;
		logic uv_prev;
		logic pf_prev;
		logic bk_prev;
		logic rst_busy;
		logic [11:0] rst_cnt;
		logic [12:0] wd_cnt;
		logic long_mode;
		logic wdo_n;
		logic reset_n;
		logic ce_out_n;
		logic pf_n;
		logic low_n;
		logic on_backup;
		logic wd_en;
		logic [3:0] evt;
		logic [3:0] evt_en;
		logic ack;
		logic [31:0] rdata;
	} swr_state_t;

	typedef struct packed {
		logic [14:0] presc;
		logic ext_prev;
		logic tick;
	} swr_tb_state_t;

endpackage : swr_pkg
`default_nettype wire

// ---- core/swr_sync.sv ----
// Two-flop synchroniser for a group of asynchronous level inputs
`timescale 1ns/1ns
`default_nettype none
module swr_sync
	import swr_pkg::*;
#(
	parameter int W = 8
)
(
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic ce, // Clock enable
	input wire logic [W-1:0] d, // Asynchronous levels
	output logic [W-1:0] q // Synchronised levels
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					s1[i] <= 1'b0;
					s2[i] <= 1'b0;
				end
				else if (ce)
				begin
					s1[i] <= d[i];
					s2[i] <= s1[i];
				end
			end
		end
	endgenerate

	assign q = s2;
endmodule : swr_sync
`default_nettype wire

// ---- core/swr_timebase.sv ----
// Timebase: one tick per internal millisecond, or per rising edge of the external clock
`timescale 1ns/1ns
`default_nettype none
module swr_timebase
	import swr_pkg::*;
#(
	parameter logic [14:0] TICK_CYCLES = 15'h4E20
)
(
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic ce, // Clock enable
	input wire logic ext_sel, // High selects the external clock
	input wire logic ext_level, // Synchronised external clock level
	output logic tick // One-cycle timebase pulse
);
	swr_tb_state_t s;
	swr_tb_state_t next_s;

	always_comb
	begin
		next_s = s;
		next_s.tick = 1'b0;
		next_s.ext_prev = ext_level;
		if (ext_sel)
		begin
			next_s.presc = 15'h0000;
			next_s.tick = ext_level && !s.ext_prev;
		end
		else if (s.presc >= TICK_CYCLES - 15'h0001)
		begin
			next_s.presc = 15'h0000;
			next_s.tick = 1'b1;
		end
		else
		begin
			next_s.presc = s.presc + 15'h0001;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

	assign tick = s.tick;
endmodule : swr_timebase
`default_nettype wire

// ---- core/swr_supervisor.sv ----
// Supervisor: reset stretch, watchdog, RAM chip-enable gating, status pins and Avalon registers
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`include "swr_params.svh"
`timescale 1ns/1ns
`default_nettype none
module swr_supervisor
	import swr_pkg::*;
#(
	parameter logic [14:0] TICK_CYCLES = 15'(`SWR_TICK_CYCLES), // System clocks per ms
	parameter bit LONG_PULSE = 1'b0, // 200 ms / 2048 clock reset pulse
	parameter bit REDUCED = 1'b0 // Fixed 1.6 s watchdog, no timebase pins
)
(
	input wire logic CLK_SYS, // 20 MHz system clock
	input wire logic RST, // Synchronous reset, active high
	input wire logic CE, // Clock enable, freezes all state when low
	input wire logic SUPPLY_BELOW_RESET, // Undervoltage comparator
	input wire logic POWER_FAIL_SENSE, // High while sense input below 1.3 V
	input wire logic MAIN_BELOW_BACKUP, // Main supply below backup supply
	input wire logic WATCHDOG_INPUT, // Watchdog service level
	input wire logic WATCHDOG_INPUT_FLOAT, // Watchdog input undriven
	input wire logic TIMEBASE_SELECT, // Low selects the external timebase
	input wire logic TIMEBASE_INPUT, // External clock or fast/slow select
	input wire logic TIMEBASE_INPUT_FLOAT, // Timebase input undriven
	input wire logic CE_IN_N, // RAM chip-enable from host
	output logic CE_OUT_N, // Gated RAM chip-enable
	output logic RESET_N, // Reset, active low
	output logic RESET, // Reset, active high
	output logic POWER_FAIL_WARN_N, // Power-fail warning
	output logic SUPPLY_LOW_N, // Supply below reset threshold
	output logic WATCHDOG_TIMEOUT_N, // Latched watchdog timeout
	output logic ON_BACKUP_SUPPLY, // Output rail on backup supply
	output logic IRQ, // Level interrupt
	input wire logic [4:0] AVS_ADDRESS, // Byte address
	input wire logic AVS_READ, // Read request
	input wire logic AVS_WRITE, // Write request
	input wire logic [3:0] AVS_BYTEENABLE, // Byte enables
	input wire logic [31:0] AVS_WRITEDATA, // Write data
	output logic [31:0] AVS_READDATA, // Read data
	output logic AVS_WAITREQUEST // Wait request
);
	swr_state_t s;
	swr_state_t next_s;
	logic [`SWR_SYNC_WIDTH-1:0] raw;
	logic [`SWR_SYNC_WIDTH-1:0] syn;
	logic tick;
	logic ext_sel;
	logic watchdog_input;
	logic wdi_float;
	logic uv;
	logic pf;
	logic bk;

	assign raw = {MAIN_BELOW_BACKUP, POWER_FAIL_SENSE, SUPPLY_BELOW_RESET, TIMEBASE_SELECT,
		TIMEBASE_INPUT_FLOAT, TIMEBASE_INPUT, WATCHDOG_INPUT_FLOAT, WATCHDOG_INPUT};

	swr_sync #(
		.W(`SWR_SYNC_WIDTH)
	) u_sync (
		.clk(CLK_SYS),
		.rst(RST),
		.ce(CE),
		.d(raw),
		.q(syn)
	);

	assign watchdog_input = syn[`SWR_SI_WDI];
	assign wdi_float = syn[`SWR_SI_WDI_FLOAT];
	assign uv = syn[`SWR_SI_UNDERVOLT];
	assign pf = syn[`SWR_SI_POWER_FAIL];
	assign bk = syn[`SWR_SI_BACKUP];
	assign ext_sel = !REDUCED && !syn[`SWR_SI_TB_SELECT];

	swr_timebase #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timebase (
		.clk(CLK_SYS),
		.rst(RST),
		.ce(CE),
		.ext_sel(ext_sel),
		.ext_level(syn[`SWR_SI_TB_LEVEL]),
		.tick(tick)
	);

	always_comb
	begin
		logic [12:0] limit;
		logic [11:0] pulse;
		logic trans;
		logic wd_run;
		logic timeout;
		logic req;
		logic [3:0] set;
		logic [3:0] clr;
		logic [31:0] rd;
		limit = `SWR_WD_SLOW_MS;
		pulse = `SWR_RST_PULSE_MS;
		trans = 1'b0;
		wd_run = 1'b0;
		timeout = 1'b0;
		req = 1'b0;
		set = 4'h0;
		clr = 4'h0;
		rd = 32'h00000000;
		next_s = s;

		// Timeout and pulse width from the selected timebase
		if (REDUCED)
			limit = `SWR_WD_SLOW_MS;
		else if (ext_sel)
			limit = s.long_mode ? `SWR_WD_AFTER_RST_CLKS : `SWR_WD_NORMAL_CLKS;
		else if (!s.long_mode && !syn[`SWR_SI_TB_FLOAT] && !syn[`SWR_SI_TB_LEVEL])
			limit = `SWR_WD_FAST_MS;
		if (ext_sel)
			pulse = LONG_PULSE ? `SWR_RST_PULSE_LONG_CLKS : `SWR_RST_PULSE_CLKS;
		else
			pulse = LONG_PULSE ? `SWR_RST_PULSE_LONG_MS : `SWR_RST_PULSE_MS;

		trans = s.wdi_valid && (watchdog_input != s.wdi_prev) && !wdi_float;
		next_s.wdi_prev = watchdog_input;
		next_s.wdi_valid = 1'b1;
		wd_run = s.wd_en && !wdi_float && !s.rst_busy && !uv;
		timeout = wd_run && !trans && tick && (s.wd_cnt + 13'h0001 >= limit);

		// Reset stretch, retriggered while the supply is low
		if (uv)
		begin
			next_s.rst_busy = 1'b1;
			next_s.rst_cnt = pulse;
			next_s.wd_cnt = 13'h0000;
		end
		else if (timeout)
		begin
			next_s.rst_busy = 1'b1;
			next_s.rst_cnt = pulse;
			next_s.wd_cnt = 13'h0000;
		end
		else if (s.rst_busy && tick)
		begin
			if (s.rst_cnt <= 12'h001)
			begin
				next_s.rst_busy = 1'b0;
				next_s.long_mode = 1'b1;
				next_s.wd_cnt = 13'h0000;
			end
			else
				next_s.rst_cnt = s.rst_cnt - 12'h001;
		end
		else if (wd_run && trans)
		begin
			next_s.wd_cnt = 13'h0000;
			next_s.long_mode = 1'b0;
		end
		else if (wd_run && tick)
			next_s.wd_cnt = s.wd_cnt + 13'h0001;

		if (timeout)
			next_s.wdo_n = 1'b0;
		if (trans)
			next_s.wdo_n = 1'b1;
		if (uv || wdi_float || !s.wd_en)
			next_s.wdo_n = 1'b1;

		next_s.reset_n = !next_s.rst_busy;
		next_s.low_n = !uv;
		next_s.pf_n = !(pf || bk);
		next_s.ce_out_n = (uv || bk) ? 1'b1 : CE_IN_N;
		next_s.on_backup = bk;

		// Sticky events; a set in the clearing cycle wins
		next_s.uv_prev = uv;
		next_s.pf_prev = pf;
		next_s.bk_prev = bk;
		set[`SWR_EV_WD_TIMEOUT] = timeout;
		set[`SWR_EV_UNDERVOLT] = uv && !s.uv_prev;
		set[`SWR_EV_POWER_FAIL] = pf && !s.pf_prev;
		set[`SWR_EV_BACKUP] = bk && !s.bk_prev;

		// Avalon slave: one wait state, write takes effect when waitrequest drops
		req = AVS_READ || AVS_WRITE;
		next_s.ack = req && !s.ack;
		if (req && !s.ack)
		begin
			unique case (AVS_ADDRESS)
				`SWR_ADDR_CTRL: rd = {31'h00000000, s.wd_en};
				`SWR_ADDR_STATUS: rd = {25'h0000000, wdi_float, s.long_mode, !s.wdo_n,
					bk, pf, uv, s.rst_busy};
				`SWR_ADDR_EVENT: rd = {28'h0000000, s.evt};
				`SWR_ADDR_EVENT_ENABLE: rd = {28'h0000000, s.evt_en};
				default: rd = 32'h00000000;
			endcase
			next_s.rdata = rd;
		end
		if (AVS_WRITE && s.ack && AVS_BYTEENABLE[0])
		begin
			unique case (AVS_ADDRESS)
				`SWR_ADDR_CTRL: next_s.wd_en = AVS_WRITEDATA[`SWR_CTRL_WD_EN];
				`SWR_ADDR_EVENT_CLEAR: clr = AVS_WRITEDATA[3:0];
				`SWR_ADDR_EVENT_ENABLE: next_s.evt_en = AVS_WRITEDATA[3:0];
				default: clr = 4'h0;
			endcase
		end
		next_s.evt = (s.evt & ~clr) | set;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			s <= '0;
			s.rst_busy <= 1'b1;
			s.rst_cnt <= LONG_PULSE ? `SWR_RST_PULSE_LONG_MS : `SWR_RST_PULSE_MS;
			s.long_mode <= 1'b1;
			s.wdo_n <= 1'b1;
			s.reset_n <= 1'b0;
			s.ce_out_n <= 1'b1;
			s.pf_n <= 1'b1;
			s.low_n <= 1'b1;
			s.wd_en <= `SWR_CTRL_RESET;
			s.evt <= `SWR_EVENT_RESET;
			s.evt_en <= `SWR_EVENT_ENABLE_RESET;
		end
		else if (CE)
			s <= next_s;
	end

	assign RESET_N = s.reset_n;
	assign RESET = !s.reset_n;
	assign CE_OUT_N = s.ce_out_n;
	assign POWER_FAIL_WARN_N = s.pf_n;
	assign SUPPLY_LOW_N = s.low_n;
	assign WATCHDOG_TIMEOUT_N = s.wdo_n;
	assign ON_BACKUP_SUPPLY = s.on_backup;
	assign IRQ = |(s.evt & s.evt_en);
	assign AVS_READDATA = s.rdata;
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !s.ack;
endmodule : swr_supervisor
`default_nettype wire

// ---- test/swr_host.sv ----
// Host model that toggles the watchdog service line at a set period
`timescale 1ns/1ns
`default_nettype none
module swr_host (
	input wire logic clk, // System clock
	input wire logic serve, // High while the host services the watchdog
	input wire logic [15:0] period, // One less than the cycles between toggles
	output logic watchdog_input // Watchdog service level
);
	logic [15:0] cnt = 16'h0000;
	logic lvl = 1'b0;
	assign watchdog_input = lvl;
	always @(posedge clk)
	begin
		cnt <= (cnt >= period) ? 16'h0000 : cnt + 16'h0001;
		if (serve && cnt == period)
			lvl <= ~lvl;
	end
endmodule : swr_host
`default_nettype wire

// ---- test/swr_monitor.sv ----
// Port checker of the supervisor block
`timescale 1ns/1ns
`default_nettype none
module swr_monitor #(
	parameter logic [14:0] TICK_CYCLES = 15'h0004,
	parameter bit LONG_PULSE = 1'b0
)
(
	input wire logic CLK_SYS, // Clock
	input wire logic RST, // Reset
	input wire logic SUPPLY_BELOW_RESET, // Undervoltage
	input wire logic POWER_FAIL_SENSE, // Power fail
	input wire logic MAIN_BELOW_BACKUP, // On backup
	input wire logic TIMEBASE_SELECT, // High selects the internal timebase
	input wire logic CE_IN_N, // Chip enable in
	input wire logic CE_OUT_N, // Chip enable out
	input wire logic RESET_N, // Reset low
	input wire logic RESET, // Reset high
	input wire logic POWER_FAIL_WARN_N, // Warning
	input wire logic SUPPLY_LOW_N, // Supply low
	input wire logic WATCHDOG_TIMEOUT_N, // Timeout
	input wire logic ON_BACKUP_SUPPLY // Backup status
);
	localparam int PW_LO = (LONG_PULSE ? 199 : 49) * int'(TICK_CYCLES) - 4;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	property p_inv; RESET == !RESET_N; endproperty
	property p_hold; SUPPLY_BELOW_RESET |-> ##[3:4] !RESET_N; endproperty
	property p_stretch;
		$rose(SUPPLY_LOW_N) && TIMEBASE_SELECT |-> ##PW_LO !RESET_N ##[1:20] RESET_N;
	endproperty
	property p_low; SUPPLY_BELOW_RESET |-> ##3 !SUPPLY_LOW_N; endproperty
	property p_up; !SUPPLY_BELOW_RESET |-> ##3 SUPPLY_LOW_N; endproperty
	property p_gate; !SUPPLY_LOW_N |-> CE_OUT_N; endproperty
	property p_pass;
		(!SUPPLY_BELOW_RESET && !MAIN_BELOW_BACKUP)[*4] |-> CE_OUT_N == $past(CE_IN_N, 1);
	endproperty
	property p_pf; POWER_FAIL_SENSE |-> ##3 !POWER_FAIL_WARN_N; endproperty
	property p_bk; MAIN_BELOW_BACKUP |-> ##3 ON_BACKUP_SUPPLY; endproperty
	property p_wdo; SUPPLY_BELOW_RESET |-> ##[3:4] WATCHDOG_TIMEOUT_N; endproperty
	property p_wdrst; $fell(WATCHDOG_TIMEOUT_N) |-> ##[0:2] !RESET_N; endproperty
	a_inv: assert property (p_inv) else $error("reset outputs not inverse");
	a_hold: assert property (p_hold) else $error("reset not held");
	a_stretch: assert property (p_stretch) else $error("reset stretch wrong");
	a_low: assert property (p_low) else $error("supply low not driven");
	a_up: assert property (p_up) else $error("supply low not released");
	a_gate: assert property (p_gate) else $error("chip enable not gated");
	a_pass: assert property (p_pass) else $error("chip enable not passed");
	a_pf: assert property (p_pf) else $error("warning not driven");
	a_bk: assert property (p_bk) else $error("backup status wrong");
	a_wdo: assert property (p_wdo) else $error("timeout not forced high");
	a_wdrst: assert property (p_wdrst) else $error("timeout without reset");
	c_timeout: cover property ($fell(WATCHDOG_TIMEOUT_N));
	c_release: cover property ($rose(RESET_N));
	c_brown: cover property ($fell(SUPPLY_LOW_N));
endmodule : swr_monitor
bind swr_supervisor swr_monitor #(.TICK_CYCLES(TICK_CYCLES), .LONG_PULSE(LONG_PULSE))
	i_swr_monitor (.CLK_SYS(CLK_SYS), .RST(RST), .SUPPLY_BELOW_RESET(SUPPLY_BELOW_RESET),
	.POWER_FAIL_SENSE(POWER_FAIL_SENSE), .MAIN_BELOW_BACKUP(MAIN_BELOW_BACKUP),
	.TIMEBASE_SELECT(TIMEBASE_SELECT),
	.CE_IN_N(CE_IN_N), .CE_OUT_N(CE_OUT_N), .RESET_N(RESET_N), .RESET(RESET),
	.POWER_FAIL_WARN_N(POWER_FAIL_WARN_N), .SUPPLY_LOW_N(SUPPLY_LOW_N),
	.WATCHDOG_TIMEOUT_N(WATCHDOG_TIMEOUT_N), .ON_BACKUP_SUPPLY(ON_BACKUP_SUPPLY));
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench of the supervisor block
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, uv = 1'b0, pf = 1'b0, mbb = 1'b0, wdf = 1'b0;
	logic tbs = 1'b1, tbi = 1'b0, tbf = 1'b0, cei = 1'b0, rd = 1'b0, wr = 1'b0, serve = 1'b0;
	logic [3:0] be = 4'hF;
	logic [4:0] addr = 5'h00;
	logic [31:0] wd = 32'h00000000, q, rdata;
	logic [15:0] per = 16'h012C;
	logic watchdog_input, ceo, rn, r, pfw, sln, watchdog_timeout_n, onb, irq, wreq;
	int errors = 0, checks = 0, cyc = 0, last = 0, falls = 0, f0, t0;
	swr_supervisor #(.TICK_CYCLES(15'h0004)) i_swr_supervisor (.CLK_SYS(clk), .RST(rst),
		.CE(ce), .SUPPLY_BELOW_RESET(uv), .POWER_FAIL_SENSE(pf), .MAIN_BELOW_BACKUP(mbb),
		.WATCHDOG_INPUT(watchdog_input), .WATCHDOG_INPUT_FLOAT(wdf), .TIMEBASE_SELECT(tbs),
		.TIMEBASE_INPUT(tbi), .TIMEBASE_INPUT_FLOAT(tbf), .CE_IN_N(cei), .CE_OUT_N(ceo),
		.RESET_N(rn), .RESET(r), .POWER_FAIL_WARN_N(pfw), .SUPPLY_LOW_N(sln),
		.WATCHDOG_TIMEOUT_N(watchdog_timeout_n), .ON_BACKUP_SUPPLY(onb), .IRQ(irq), .AVS_ADDRESS(addr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wd),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq));
	swr_host i_swr_host (.clk(clk), .serve(serve), .period(per), .watchdog_input(watchdog_input));
	initial
	begin
		forever #25 clk = ~clk;
	end
	always @(watchdog_input) last = cyc;
	always @(negedge rn) falls++;
	// External timebase: one rising edge every other cycle while selected
	always @(posedge clk) tbi <= !tbs && !tbi;
	task end_sim;
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			errors++;
			end_sim;
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e)
		begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		do
			@(posedge clk);
		while (wreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t0 = cyc;
		wait (rn === 1'b1);
		chk("stretch", 32'h1, {31'h0, cyc - t0 >= 196});
		bus(1'b0, 5'h00, 32'h0);
		chk("ctrl", 32'h1, q);
		bus(1'b0, 5'h14, 32'h0);
		chk("unmapped", 32'h0, q);
		bus(1'b1, 5'h10, 32'h0000000F);
		bus(1'b0, 5'h0C, 32'h0);
		chk("event_clear", 32'h0, q);
		serve <= 1'b1;
		f0 = falls;
		repeat (8000) @(posedge clk);
		chk("serviced", f0, falls);
		serve <= 1'b0;
		wait (watchdog_timeout_n === 1'b0);
		chk("fast_timeout", 32'h1, {31'h0, cyc - last >= 390 && cyc - last <= 412});
		repeat (3) @(posedge clk);
		chk("wd_reset", 32'h0, rn);
		bus(1'b0, 5'h08, 32'h0);
		chk("event", 32'h1, q);
		chk("irq", 32'h1, irq);
		f0 = falls;
		repeat (7000) @(posedge clk);
		chk("repeat", f0 + 1, falls);
		chk("wdo_held", 32'h0, watchdog_timeout_n);
		serve <= 1'b1;
		wait (watchdog_timeout_n === 1'b1);
		chk("wdo_release", 32'h1, {31'h0, cyc - last <= 8});
		bus(1'b1, 5'h0C, 32'h1);
		bus(1'b0, 5'h08, 32'h0);
		chk("event", 32'h0, q);
		@(posedge clk);
		chk("irq", 32'h0, irq);
		serve <= 1'b0;
		wait (watchdog_timeout_n === 1'b0);
		wait (rn === 1'b1);
		@(posedge clk);
		uv <= 1'b1;
		repeat (5) @(posedge clk);
		chk("supply_low", 32'h0, sln);
		chk("ce_out", 32'h1, ceo);
		chk("reset_n", 32'h0, rn);
		chk("wdo", 32'h1, watchdog_timeout_n);
		uv <= 1'b0;
		repeat (5) @(posedge clk);
		chk("supply_low", 32'h1, sln);
		chk("reset_n", 32'h0, rn);
		chk("ce_out", 32'h0, ceo);
		cei <= 1'b1;
		repeat (2) @(posedge clk);
		chk("ce_pass", 32'h1, ceo);
		cei <= 1'b0;
		bus(1'b0, 5'h08, 32'h0);
		chk("event", 32'h3, q);
		chk("irq", 32'h1, irq);
		bus(1'b1, 5'h10, 32'h0);
		@(posedge clk);
		chk("irq_masked", 32'h0, irq);
		pf <= 1'b1;
		mbb <= 1'b1;
		repeat (5) @(posedge clk);
		chk("warn", 32'h0, pfw);
		chk("backup", 32'h1, onb);
		pf <= 1'b0;
		mbb <= 1'b0;
		repeat (5) @(posedge clk);
		chk("warn", 32'h1, pfw);
		chk("backup", 32'h0, onb);
		wait (rn === 1'b1);
		@(posedge clk);
		wdf <= 1'b1;
		serve <= 1'b0;
		f0 = falls;
		repeat (8000) @(posedge clk);
		chk("float", f0, falls);
		chk("float_wdo", 32'h1, watchdog_timeout_n);
		tbs <= 1'b0;
		uv <= 1'b1;
		repeat (5) @(posedge clk);
		uv <= 1'b0;
		wait (sln === 1'b1);
		t0 = cyc;
		wait (rn === 1'b1);
		chk("ext_pulse", 32'h1, {31'h0, cyc - t0 >= 1016 && cyc - t0 <= 1030});
		end_sim;
	end
endmodule : tb
`default_nettype wire
